// ==== shared/sleep_ctrl_map.svh ====
// Register offsets, bit positions and timing counts of the sleep controller
`ifndef SLEEP_CTRL_MAP_SVH
`define SLEEP_CTRL_MAP_SVH
`define OFS_MAIN_CONTROL     4'h0
`define OFS_STATUS_CONTROL   4'h4
`define OFS_EXT_CONTROL      4'h8
`define OFS_SLEEP_STATUS     4'hc
`define BIT_SLEEP_ARM        5
`define BIT_SEL_MID          4
`define BIT_SEL_HI           5
`define BIT_SEL_LO           7
`define RST_MAIN_CONTROL     8'h00
`define RST_STATUS_CONTROL   8'h00
`define RST_EXT_CONTROL      8'h00
`define CODE_IDLE            3'h0
`define CODE_PDOWN           3'h2
`define CODE_PSAVE           3'h3
`define CODE_STANDBY         3'h6
`define CODE_XSTANDBY        3'h7
`define STANDBY_WAKE_CYCLES  8'h06
`define HALT_EXTRA_CYCLES    8'h04
`define STARTUP_CYCLES_DEF   8'h10
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

// ==== shared/sleep_ctrl_pkg.sv ====
// Types shared by the sleep controller files
package sleep_ctrl_pkg;
   typedef enum logic [2:0] {
      MODE_IDLE, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY, MODE_XSTANDBY,
      MODE_NONE
   } sleep_mode_t;
   typedef struct packed {
      logic core_clk_en;
      logic flash_clk_en;
      logic io_clk_en;
      logic async_clk_en;
      logic main_osc_en;
      logic timer_osc_en;
   } clk_gate_t;
   typedef struct packed {
      logic ext_irq;
      logic pin_change;
      logic async_timer_irq;
      logic store_ready_irq;
      logic other_io_irq;
   } wake_src_t;
endpackage

// ==== verification/cpu_core_model.sv ====
// CPU core model that issues sleep operations and takes resumes
`timescale 1ns/1ps
module cpu_core_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic irq_resume,
   output logic      sleep_op
);
   int resumes;
   initial sleep_op = 1'b0;
   // One-cycle pulse, as a single sleep instruction gives
   task automatic do_sleep();
      @(posedge clk);
      sleep_op <= 1'b1;
      @(posedge clk);
      sleep_op <= 1'b0;
   endtask
   // Handler entries counted so a reset wake can be told apart
   always @(posedge clk or negedge resetn) begin
      if (!resetn) resumes <= 0;
      else if (irq_resume === 1'b1) resumes <= resumes + 1;
   end
endmodule // cpu_core_model

// ==== verification/tb_sleep_mode_controller.sv ====
// Register and sleep sequence tests of the sleep mode controller
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"
module tb_sleep_mode_controller
   import sleep_ctrl_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic sleep_op, crystal = 1'b1, acs = 1'b1, reset_wake = 1'b0;
   wake_src_t wake_src = 5'h00;
   clk_gate_t gates;
   logic core_halt, irq_resume, asleep;
   logic [31:0] d;
   logic [1:0] r;
   int error_cnt = 0, total_checks = 0, cycles = 0, n0, i;
   always #5 clk = ~clk;
   sleep_mode_controller DUT (.clk(clk), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .sleep_op(sleep_op), .crystal_source(crystal),
      .async_clock_select(acs), .startup_cycles(8'h02),
      .wake_src(wake_src), .reset_wake(reset_wake), .gates(gates),
      .core_halt(core_halt), .irq_resume(irq_resume), .asleep(asleep));
   cpu_core_model core (.clk(clk), .resetn(resetn),
      .irq_resume(irq_resume), .sleep_op(sleep_op));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Bounded cycle budget, a hang counts as a mismatch
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
      bready <= 1'b1;
      // No local limit: a missing answer is caught by the cycle budget
      forever begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [3:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata; r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic set_mode(input logic [2:0] c, input logic arm);
      logic [31:0] v;
      v = 32'h0; v[`BIT_SLEEP_ARM] = arm; v[`BIT_SEL_MID] = c[1];
      axi_wr(`OFS_MAIN_CONTROL, v);
      v = 32'h0; v[`BIT_SEL_HI] = c[2];
      axi_wr(`OFS_STATUS_CONTROL, v);
      v = 32'h0; v[`BIT_SEL_LO] = c[0];
      axi_wr(`OFS_EXT_CONTROL, v);
   endtask
   task automatic no_sleep(input logic [2:0] c, input logic arm);
      set_mode(c, arm);
      core.do_sleep();
      repeat (3) @(posedge clk);
      #1;
      chk("asleep_refused", 32'h0, {31'h0, asleep});
      chk("gates_refused", 32'h3f, {26'h0, gates});
   endtask
   task automatic run_mode(input logic [2:0] c, input logic [2:0] idx,
      input logic [5:0] g, input logic [4:0] bad, input logic [4:0] good,
      input int extra);
      int n;
      set_mode(c, 1'b1);
      axi_rd(`OFS_SLEEP_STATUS);
      chk("mode", {29'h0, idx}, {29'h0, d[2:0]});
      n0 = core.resumes;
      core.do_sleep();
      #1;
      chk("asleep", 32'h1, {31'h0, asleep});
      chk("gates", {26'h0, g}, {26'h0, gates});
      @(posedge clk) wake_src <= bad;
      repeat (8) @(posedge clk);
      #1;
      chk("asleep_bad_src", 32'h1, {31'h0, asleep});
      @(posedge clk) wake_src <= good;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (irq_resume !== 1'b1 && n < 100);
      chk("wake_latency", 32'h1, {31'h0, n >= extra && n <= extra + 2});
      chk("halt_after", 32'h0, {31'h0, core_halt});
      chk("gates_after", 32'h3f, {26'h0, gates});
      @(posedge clk) wake_src <= 5'h00;
      set_mode(c, 1'b0);
      chk("resumes", n0 + 1, core.resumes);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      axi_rd(`OFS_MAIN_CONTROL);
      chk("main_rst", {24'h0, `RST_MAIN_CONTROL}, d);
      axi_rd(`OFS_STATUS_CONTROL);
      chk("status_rst", {24'h0, `RST_STATUS_CONTROL}, d);
      axi_rd(`OFS_EXT_CONTROL);
      chk("ext_rst", {24'h0, `RST_EXT_CONTROL}, d);
      axi_wr(4'h2, 32'hff);
      chk("unmapped_resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
      set_mode(3'h7, 1'b0);
      axi_rd(`OFS_MAIN_CONTROL);
      chk("main_rw", 32'h10, d);
      axi_rd(`OFS_STATUS_CONTROL);
      chk("status_rw", 32'h20, d);
      axi_rd(`OFS_EXT_CONTROL);
      chk("ext_rw", 32'h80, d);
      $display("test registers done");
      no_sleep(3'h7, 1'b0);
      for (i = 0; i < 3; i++) no_sleep(i == 0 ? 3'h1 : 3'(i + 3), 1'b1);
      crystal <= 1'b0;
      no_sleep(3'h6, 1'b1);
      no_sleep(3'h7, 1'b1);
      crystal <= 1'b1;
      $display("test refusals done");
      run_mode(3'h0, 3'h0, 6'h0f, 5'h00, 5'h01, 4);
      run_mode(3'h2, 3'h1, 6'h00, 5'h01, 5'h08, 6);
      run_mode(3'h3, 3'h2, 6'h05, 5'h02, 5'h04, 6);
      run_mode(3'h6, 3'h3, 6'h02, 5'h04, 5'h10, 4);
      run_mode(3'h7, 3'h4, 6'h07, 5'h01, 5'h04, 4);
      acs <= 1'b0;
      run_mode(3'h7, 3'h4, 6'h02, 5'h04, 5'h10, 4);
      acs <= 1'b1;
      $display("test modes done");
      set_mode(3'h2, 1'b1);
      n0 = core.resumes;
      core.do_sleep();
      @(posedge clk) reset_wake <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("asleep_reset", 32'h0, {31'h0, asleep});
      chk("gates_reset", 32'h3f, {26'h0, gates});
      @(posedge clk) reset_wake <= 1'b0;
      repeat (6) @(posedge clk);
      chk("resumes_reset", n0, core.resumes);
      $display("test reset wake done");
      finish_test();
   end
endmodule // tb_sleep_mode_controller

// ==== verilog/sleep_mode_controller.sv ====
// Sleep mode controller with AXI4-Lite register access
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"
module sleep_mode_controller
   import sleep_ctrl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sleep_op,
   input  wire logic        crystal_source,
   input  wire logic        async_clock_select,
   input  wire logic [7:0]  startup_cycles,
   input  wire wake_src_t   wake_src,
   input  wire logic        reset_wake,
   output clk_gate_t        gates,
   output logic             core_halt,
   output logic             irq_resume,
   output logic             asleep
);
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} state_t;

   logic [7:0]  mcu_main_control;
   logic [7:0]  mcu_status_and_control;
   logic [7:0]  mcu_extended_control;
   state_t      state;
   logic [7:0]  wait_cnt;
   sleep_mode_t cur_mode;
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // Decode of the three scattered select bits
   wire [2:0] sel = {mcu_status_and_control[`BIT_SEL_HI],
                     mcu_main_control[`BIT_SEL_MID],
                     mcu_extended_control[`BIT_SEL_LO]};
   wire sleep_arm = mcu_main_control[`BIT_SLEEP_ARM];
   sleep_mode_t sel_mode;
   clk_gate_t   sel_gates;
   wire         h_ext;
   wire         h_timer;
   wire         h_io;

   sleep_mode_decode u_decode (
      .sel                (sel),
      .crystal_source     (crystal_source),
      .async_clock_select (async_clock_select),
      .mode               (sel_mode),
      .gates              (sel_gates),
      .honour_ext         (h_ext),
      .honour_timer       (h_timer),
      .honour_io          (h_io)
   );

   // Wake filter per mode; select is frozen by halted core while asleep
   wire irq_wake = (h_ext && (wake_src.ext_irq || wake_src.pin_change))
                || (h_timer && wake_src.async_timer_irq)
                || (h_io && (wake_src.store_ready_irq
                             || wake_src.other_io_irq));
   wire enter = sleep_op && sleep_arm && (sel_mode != MODE_NONE);
   wire fast_wake = (cur_mode == MODE_STANDBY)
                 || (cur_mode == MODE_XSTANDBY)
                 || (cur_mode == MODE_IDLE);
   // Oscillator restart costs the start-up time, then four halted cycles
   wire [7:0] wake_len = fast_wake ? `HALT_EXTRA_CYCLES
                       : 8'(startup_cycles + `HALT_EXTRA_CYCLES);
   logic [7:0] next_cnt;
   assign next_cnt = (wait_cnt == 8'h00) ? 8'h00 : 8'(wait_cnt - 8'h01);

   // Sleep sequencer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state    <= ST_RUN;
         wait_cnt <= 8'h00;
         cur_mode <= MODE_NONE;
      end else begin
         case (state)
            ST_RUN: begin
               if (enter) begin
                  state    <= ST_SLEEP;
                  cur_mode <= sel_mode;
               end
            end
            ST_SLEEP: begin
               if (reset_wake) begin
                  state <= ST_RUN;
               end else if (irq_wake) begin
                  state    <= ST_WAKE;
                  wait_cnt <= 8'(wake_len - 8'h01);
               end
            end
            ST_WAKE: begin
               wait_cnt <= next_cnt;
               if (wait_cnt == 8'h00) begin
                  state <= ST_RUN;
               end
            end
            default: state <= ST_RUN;
         endcase
      end
   end

   wire run_next = (state == ST_WAKE) && (wait_cnt == 8'h00);
   // Registered outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gates      <= '1;
         core_halt  <= 1'b0;
         irq_resume <= 1'b0;
         asleep     <= 1'b0;
      end else begin
         gates      <= (state == ST_RUN && enter) ? sel_gates
                     : (state == ST_SLEEP && !reset_wake) ? gates
                     : '1;
         core_halt  <= (state == ST_RUN) ? enter : !run_next
                       && !(state == ST_SLEEP && reset_wake);
         irq_resume <= run_next;
         asleep     <= (state == ST_RUN) ? enter
                     : (state == ST_SLEEP) && !reset_wake && !irq_wake;
      end
   end

   // AXI4-Lite slave: address and data taken in either order
   wire aw_ok  = aw_held || s_axi_awvalid;
   wire w_ok   = w_held || s_axi_wvalid;
   wire do_wr  = aw_ok && w_ok && !s_axi_bvalid;
   wire [3:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
   wire wr_hit = (wa == `OFS_MAIN_CONTROL) || (wa == `OFS_STATUS_CONTROL)
              || (wa == `OFS_EXT_CONTROL);
   wire wr0 = do_wr && ws[0];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 4'h0;
         w_data        <= 32'h0;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid
                          && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid
                          && !s_axi_bvalid;
         if (s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   wire commit = aw_held && w_held && !s_axi_bvalid && ws[0];
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mcu_main_control       <= `RST_MAIN_CONTROL;
         mcu_status_and_control <= `RST_STATUS_CONTROL;
         mcu_extended_control   <= `RST_EXT_CONTROL;
      end else if (commit) begin
         if (wa == `OFS_MAIN_CONTROL)   mcu_main_control       <= wd[7:0];
         if (wa == `OFS_STATUS_CONTROL) mcu_status_and_control <= wd[7:0];
         if (wa == `OFS_EXT_CONTROL)    mcu_extended_control   <= wd[7:0];
      end
   end

   // Read channel, one access at a time
   wire rd_hit = (s_axi_araddr == `OFS_MAIN_CONTROL)
              || (s_axi_araddr == `OFS_STATUS_CONTROL)
              || (s_axi_araddr == `OFS_EXT_CONTROL)
              || (s_axi_araddr == `OFS_SLEEP_STATUS);
   wire [7:0] rd_val =
      (s_axi_araddr == `OFS_MAIN_CONTROL)   ? mcu_main_control :
      (s_axi_araddr == `OFS_STATUS_CONTROL) ? mcu_status_and_control :
      (s_axi_araddr == `OFS_EXT_CONTROL)    ? mcu_extended_control :
      (s_axi_araddr == `OFS_SLEEP_STATUS)   ? {5'h00, sel_mode} : 8'h00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_val};
            s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Assertions
   a_arm_needed: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_RUN && sleep_op && !sleep_arm) |=> state == ST_RUN)
      else $error("sleep entered while disarmed");
   a_reserved_noop: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_RUN && sel_mode == MODE_NONE) |=> state == ST_RUN)
      else $error("reserved code entered sleep");
   a_code_idle: assert property (@(posedge clk) disable iff (!resetn)
      (sel == 3'h0) |-> sel_mode == MODE_IDLE)
      else $error("idle code misdecoded");
   a_xtal_needed: assert property (@(posedge clk) disable iff (!resetn)
      !crystal_source |-> (sel_mode != MODE_STANDBY
                           && sel_mode != MODE_XSTANDBY))
      else $error("standby without crystal");
   a_idle_gates: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_RUN && enter && sel_mode == MODE_IDLE) |=>
      (!gates.core_clk_en && gates.io_clk_en))
      else $error("idle gating wrong");
   a_pdown_gates: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_RUN && enter && sel_mode == MODE_PDOWN) |=>
      (gates == '0))
      else $error("power-down left a clock on");
   a_pdown_no_io: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_SLEEP && cur_mode == MODE_PDOWN && !reset_wake
       && !wake_src.ext_irq && !wake_src.pin_change) |=> state == ST_SLEEP)
      else $error("power-down woke on io source");
   a_standby_six: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_SLEEP && irq_wake && !reset_wake
       && cur_mode == MODE_STANDBY) |-> ##[1:6] irq_resume)
      else $error("standby wake too slow");
   a_extra_four: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_SLEEP && irq_wake && !reset_wake && fast_wake) |->
      ##5 irq_resume)
      else $error("wake halt length wrong");
   c_idle_wake: cover property (@(posedge clk) disable iff (!resetn)
      cur_mode == MODE_IDLE && irq_resume);
   c_pdown_wake: cover property (@(posedge clk) disable iff (!resetn)
      cur_mode == MODE_PDOWN && irq_resume);
   c_xstby_wake: cover property (@(posedge clk) disable iff (!resetn)
      cur_mode == MODE_XSTANDBY && irq_resume);
endmodule // sleep_mode_controller

// ==== verilog/sleep_mode_decode.sv ====
// Sleep select decode into mode, clock gates and wake filter
`timescale 1ns/1ps
`include "sleep_ctrl_map.svh"
module sleep_mode_decode
   import sleep_ctrl_pkg::*;
(
   input  wire logic [2:0]  sel,
   input  wire logic        crystal_source,
   input  wire logic        async_clock_select,
   output sleep_mode_t      mode,
   output clk_gate_t        gates,
   output wire logic        honour_ext,
   output wire logic        honour_timer,
   output wire logic        honour_io
);
   wire is_idle  = (sel == `CODE_IDLE);
   wire is_pdown = (sel == `CODE_PDOWN);
   wire is_psave = (sel == `CODE_PSAVE);
   wire is_stby  = (sel == `CODE_STANDBY) && crystal_source;
   wire is_xstby = (sel == `CODE_XSTANDBY) && crystal_source;
   wire async_on = (is_psave || is_xstby) && async_clock_select;
   // Reserved codes and crystal-less standby map to no mode at all
   assign mode = is_idle  ? MODE_IDLE  :
                 is_pdown ? MODE_PDOWN :
                 is_psave ? MODE_PSAVE :
                 is_stby  ? MODE_STANDBY :
                 is_xstby ? MODE_XSTANDBY : MODE_NONE;
   assign gates.core_clk_en  = 1'b0;
   assign gates.flash_clk_en = 1'b0;
   assign gates.io_clk_en    = is_idle;
   assign gates.async_clk_en = is_idle || async_on;
   assign gates.main_osc_en  = is_idle || is_stby || is_xstby;
   assign gates.timer_osc_en = is_idle ? async_clock_select
                                       : async_on;
   assign honour_ext   = 1'b1;
   assign honour_timer = is_idle || async_on;
   assign honour_io    = is_idle;
endmodule // sleep_mode_decode
